// ---- memory_map_and_stack_irq_gate_test.sv ----
`timescale 1ns/10ps
`default_nettype none
module memory_map_and_stack_irq_gate_test;
  logic ref_clk = 1'b0;
  logic reset   = 1'b1;
  wire logic prog_req, op_call, op_ret, op_npush, op_npop, data_req, data_wr, nmi_req;
  wire logic wide_stack_pointer_wr, nibble_stack_pointer_wr, flag_wr, prog_hit_q, op_ready;
  wire logic int_ack_q, pc_load_q, gate_open;
  wire logic mem_req_q, mem_wr_q, mem_wide_q, sel_ram_q, sel_drom_q, sel_disp_q, sel_io_q;
  wire logic map_err_q;
  wire logic [15:0] prog_addr, call_pc, data_addr, cur_pc, pc_load_addr_q, mem_addr_q;
  wire logic [15:0] mem_wdata_q;
  wire logic [12:0] prog_rom_addr_q;
  wire logic [7:0]  sp_wdata, wide_stack_pointer_q, nibble_stack_pointer_q;
  wire logic [5:0]  irq_req;
  wire logic [3:0]  npush_data, data_wdata, flag_wdata, flags_q;
  int mismatches = 0;
  int samples_checked = 0;
  int acks = 0;
  logic [38:0] log_q[$];
  logic [15:0] dec_a [7] = '{16'h0000, 16'h13FF, 16'h1400, 16'h8000, 16'h87FF, 16'hF000, 16'hFF00};
  logic [4:0]  dec_s [7] = '{5'h01, 5'h01, 5'h10, 5'h02, 5'h02, 5'h04, 5'h08};
  logic [15:0] prog_a [3] = '{16'h0000, 16'h1FFF, 16'h2000};

  mmsig_gate i_dut (.ref_clk, .reset, .prog_req, .prog_addr, .prog_hit_q, .prog_rom_addr_q,
    .op_call, .call_pc, .op_ret, .op_npush, .op_npop, .npush_data, .data_req, .data_wr,
    .data_addr, .data_wdata, .wide_stack_pointer_wr, .nibble_stack_pointer_wr, .sp_wdata,
    .flag_wr, .flag_wdata, .op_ready,
    .nmi_req, .irq_req, .cur_pc, .int_ack_q, .pc_load_q, .pc_load_addr_q, .gate_open,
    .wide_stack_pointer_q, .nibble_stack_pointer_q, .flags_q, .mem_req_q, .mem_wr_q,
    .mem_wide_q, .mem_addr_q, .mem_wdata_q, .sel_ram_q, .sel_drom_q, .sel_disp_q, .sel_io_q,
    .map_err_q);

  mmsig_cpu_model i_cpu (.ref_clk, .op_ready, .prog_req, .prog_addr, .op_call, .call_pc,
    .op_ret, .op_npush, .op_npop, .npush_data, .data_req, .data_wr, .data_addr, .data_wdata,
    .wide_stack_pointer_wr, .nibble_stack_pointer_wr, .sp_wdata, .flag_wr, .flag_wdata,
    .nmi_req, .irq_req, .cur_pc);

  always #50 ref_clk = ~ref_clk;

  // Settled sampling; read data is not specified, so it is logged as zero
  always @(negedge ref_clk) begin
    if (int_ack_q === 1'b1) acks++;
    if (mem_req_q === 1'b1) begin
      log_q.push_back({map_err_q, sel_io_q, sel_disp_q, sel_drom_q, sel_ram_q, mem_wr_q,
                       mem_wide_q, mem_addr_q, mem_wr_q ? mem_wdata_q : 16'h0000});
    end
  end

  task automatic chk(input string n, input logic [38:0] e, input logic [38:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] g);
    chk(n, {23'h0, e}, {23'h0, g});
  endtask

  task automatic pop(input string n, input logic [38:0] e, input logic [38:0] m = {39{1'b1}});
    logic [38:0] g;
    g = {39{1'bx}};
    if (log_q.size() > 0) g = log_q.pop_front();
    chk(n, e & m, g & m);
  endtask

  function automatic logic [38:0] acc(input logic [4:0] s, input logic w, input logic wd,
                                      input logic [15:0] a, input logic [15:0] d);
    return {s, w, wd, a, d};
  endfunction

  task automatic run(input int kind, input logic [15:0] a, input logic [7:0] d);
    i_cpu.op(kind, a, d);
    repeat (2) @(negedge ref_clk);
  endtask

  task automatic pulse_nmi();
    @(posedge ref_clk);
    #1 i_cpu.nmi_req = 1'b1;
    @(posedge ref_clk);
    #1 i_cpu.nmi_req = 1'b0;
  endtask

  task automatic wait_ack(input string n, input logic [15:0] vec);
    int k;
    k = 0;
    while (int_ack_q !== 1'b1 && k < 12) begin
      @(negedge ref_clk);
      k++;
    end
    chk(n, {21'h0, 2'b11, vec}, {21'h0, int_ack_q, pc_load_q, pc_load_addr_q});
  endtask

  task automatic t_prog();
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk);
      #1 i_cpu.prog_req = 1'b1;
      i_cpu.prog_addr = prog_a[i];
      @(posedge ref_clk);
      #1 i_cpu.prog_req = 1'b0;
      @(negedge ref_clk);
      chk16("fetch", {2'b00, i < 2, prog_a[i][12:0]}, {2'b00, prog_hit_q, prog_rom_addr_q});
    end
  endtask

  task automatic t_decode();
    for (int i = 0; i < 7; i++) begin
      run(4, dec_a[i], 8'h00);
      pop("decode", acc(dec_s[i], 1'b0, 1'b0, dec_a[i], 16'h0000));
    end
    run(5, 16'h0150, 8'h0A);
    pop("nibble write", acc(5'h01, 1'b1, 1'b0, 16'h0150, 16'h000A));
    run(5, 16'h8000, 8'h03);
    pop("rom write", acc(5'h12, 1'b1, 1'b0, 16'h8000, 16'h0003));
  endtask

  task automatic t_gate();
    pulse_nmi();
    run(6, 16'h0000, 8'h48);
    chk16("gate one ptr", 16'h0000, {15'h0, gate_open});
    run(7, 16'h0000, 8'h20);
    chk16("gate both", 16'h0001, {15'h0, gate_open});
    run(6, 16'h0000, 8'h48);
    chk16("gate reclosed", 16'h0000, {15'h0, gate_open});
    pulse_nmi();
    repeat (8) @(negedge ref_clk);
    chk16("masked nmi", 16'h0000, acks[15:0]);
    run(7, 16'h0000, 8'h20);
    chk16("gate reopened", 16'h0001, {15'h0, gate_open});
  endtask

  task automatic t_stack();
    run(6, 16'h0000, 8'h41); // Kept inside the wide window
    run(0, 16'h1234, 8'h00);
    pop("call push", acc(5'h01, 1'b1, 1'b1, 16'h0100, 16'h1234));
    chk16("call ptr", 16'h0040, {8'h00, wide_stack_pointer_q});
    run(1, 16'h0000, 8'h00);
    pop("ret pop", acc(5'h01, 1'b0, 1'b1, 16'h0100, 16'h0000));
    chk16("ret ptr", 16'h0041, {8'h00, wide_stack_pointer_q});
    run(6, 16'h0000, 8'h00);
    run(0, 16'hABCD, 8'h00);
    pop("wide wrap", acc(5'h11, 1'b1, 1'b1, 16'h03FC, 16'hABCD));
    chk16("wide wrap ptr", 16'h00FF, {8'h00, wide_stack_pointer_q});
    run(1, 16'h0000, 8'h00);
    log_q.delete();
    chk16("wide wrap back", 16'h0000, {8'h00, wide_stack_pointer_q});
    run(7, 16'h0000, 8'h00);
    run(2, 16'h0000, 8'h05);
    pop("nibble push", acc(5'h01, 1'b1, 1'b0, 16'h00FF, 16'h0005));
    run(3, 16'h0000, 8'h00);
    pop("nibble pop", acc(5'h01, 1'b0, 1'b0, 16'h00FF, 16'h0000));
    chk16("nibble wrap", 16'h0000, {8'h00, nibble_stack_pointer_q});
  endtask

  task automatic t_irq();
    logic [7:0] p;
    run(8, 16'h0000, 8'h48);
    for (int i = 0; i < 7; i++) begin
      p = 8'h47 - i[7:0];
      run(9, 16'h0000, 8'h04);
      @(posedge ref_clk);
      #1 i_cpu.cur_pc = 16'h0700 + i[15:0];
      if (i < 6) i_cpu.irq_req = 6'h01 << i;
      else i_cpu.nmi_req = 1'b1;
      @(posedge ref_clk);
      #1 i_cpu.nmi_req = 1'b0; // One-cycle pulse, or a second entry follows
      wait_ack("vector", (i < 6) ? 16'h0104 + 16'(2 * i) : 16'h0100);
      @(posedge ref_clk);
      #1 {i_cpu.irq_req, i_cpu.nmi_req} = 7'h00;
      pop("entry pc", acc(5'h01, 1'b1, 1'b1, {6'h00, p, 2'b00}, 16'h0700 + i[15:0]));
      pop("entry flags", acc(5'h01, 1'b1, 1'b0, {8'h00, p}, 16'h0004));
      chk16("flag I cleared", 16'h0000, {12'h000, flags_q});
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #1000000;
    mismatches++;
    tally_and_finish();
  end

  initial begin
    repeat (4) @(negedge ref_clk);
    chk16("reset pc", 16'h0110, pc_load_addr_q);
    chk16("reset flags", 16'h0001, {11'h000, flags_q, pc_load_q});
    chk16("reset gate", 16'h0000, {15'h0, gate_open});
    @(posedge ref_clk);
    #1 reset = 1'b0;
    t_prog();
    t_decode();
    t_gate();
    t_stack();
    t_irq();
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ---- mmsig_cpu_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module mmsig_cpu_model (
  input  wire logic        ref_clk,    // System clock
  input  wire logic        op_ready,   // Block takes ops this cycle
  output var  logic        prog_req,   // Fetch strobe
  output var  logic [15:0] prog_addr,  // Fetch step
  output var  logic        op_call,    // Call
  output var  logic [15:0] call_pc,    // Return PC
  output var  logic        op_ret,     // Return
  output var  logic        op_npush,   // Nibble push
  output var  logic        op_npop,    // Nibble pop
  output var  logic [3:0]  npush_data, // Pushed nibble
  output var  logic        data_req,   // Plain access
  output var  logic        data_wr,    // Write
  output var  logic [15:0] data_addr,  // Address
  output var  logic [3:0]  data_wdata, // Write nibble
  output var  logic        wide_stack_pointer_wr,   // Wide pointer load
  output var  logic        nibble_stack_pointer_wr, // Nibble pointer load
  output var  logic [7:0]  sp_wdata,   // Pointer value
  output var  logic        flag_wr,    // Flag load
  output var  logic [3:0]  flag_wdata, // Flag value
  output var  logic        nmi_req,    // NMI pulse
  output var  logic [5:0]  irq_req,    // Interrupt levels
  output var  logic [15:0] cur_pc      // PC saved on entry
);
  // Idle bus; no sleep request exists in this model
  task automatic quiet();
    {op_call, op_ret, op_npush, op_npop, data_req, data_wr, flag_wr} = 7'h00;
    {wide_stack_pointer_wr, nibble_stack_pointer_wr} = 2'h0;
    {call_pc, data_addr, npush_data, data_wdata, sp_wdata, flag_wdata} = 52'h0;
  endtask

  initial begin
    quiet();
    {prog_req, prog_addr, nmi_req, irq_req, cur_pc} = 40'h0;
  end

  // Request held until op_ready is seen high at a falling edge, then dropped after the next rising edge
  task automatic op(input int kind, input logic [15:0] a, input logic [7:0] d);
    logic rdy;
    @(posedge ref_clk);
    #1;
    case (kind)
      0: begin op_call = 1'b1; call_pc = a; end
      1: op_ret = 1'b1;
      2: begin op_npush = 1'b1; npush_data = d[3:0]; end
      3: op_npop = 1'b1;
      4, 5: begin data_req = 1'b1; data_wr = (kind == 5); data_addr = a; data_wdata = d[3:0]; end
      6, 8: begin
        wide_stack_pointer_wr = 1'b1;
        nibble_stack_pointer_wr = (kind == 8);
        sp_wdata = d;
      end
      7: begin
        nibble_stack_pointer_wr = 1'b1;
        sp_wdata = d;
      end
      default: begin flag_wr = 1'b1; flag_wdata = d[3:0]; end
    endcase
    do begin
      @(negedge ref_clk);
      rdy = op_ready;
      @(posedge ref_clk);
    end while (rdy !== 1'b1);
    #1;
    quiet();
  endtask
endmodule
`default_nettype wire

// ---- mmsig_gate.sv ----
`timescale 1ns/10ps
`default_nettype none
module mmsig_gate #(
  parameter int          IRQ_COUNT  = 6,
  parameter logic [15:0] DISP_FIRST = mmsig_pkg::DISP_FIRST_DEF,
  parameter logic [15:0] DISP_LAST  = mmsig_pkg::DISP_LAST_DEF,
  parameter logic [15:0] IO_FIRST   = mmsig_pkg::IO_FIRST_DEF,
  parameter logic [15:0] IO_LAST    = mmsig_pkg::IO_LAST_DEF
) (
  input  wire logic                 ref_clk,        // System clock, 10 MHz
  input  wire logic                 reset,          // Initial reset, sync, high
  input  wire logic                 prog_req,       // Program fetch strobe
  input  wire logic [15:0]          prog_addr,      // Program step address
  output logic                      prog_hit_q,     // Fetch lands in code ROM
  output logic [12:0]               prog_rom_addr_q,// Code ROM step index
  input  wire logic                 op_call,        // Call: push return PC
  input  wire logic [15:0]          call_pc,        // Return PC for the call
  input  wire logic                 op_ret,         // Pop PC from wide stack
  input  wire logic                 op_npush,       // Push nibble
  input  wire logic                 op_npop,        // Pop nibble
  input  wire logic [3:0]           npush_data,     // Nibble to push
  input  wire logic                 data_req,       // Plain 4-bit data access
  input  wire logic                 data_wr,        // Access is a write
  input  wire logic [15:0]          data_addr,      // Data address
  input  wire logic [3:0]           data_wdata,     // Write nibble
  input  wire logic                 wide_stack_pointer_wr,   // Load wide stack pointer
  input  wire logic                 nibble_stack_pointer_wr, // Load nibble stack pointer
  input  wire logic [7:0]           sp_wdata,       // Pointer load value
  input  wire logic                 flag_wr,        // Load flag register
  input  wire logic [3:0]           flag_wdata,     // Flag load value
  output logic                      op_ready,       // Ops and loads accepted
  input  wire logic                 nmi_req,        // NMI request pulse
  input  wire logic [IRQ_COUNT-1:0] irq_req,        // Hardware interrupt levels
  input  wire logic [15:0]          cur_pc,         // PC to save on entry
  output logic                      int_ack_q,      // Entry done, vector loaded
  output logic                      pc_load_q,      // Load PC pulse
  output logic [15:0]               pc_load_addr_q, // PC load value
  output logic                      gate_open,      // Interrupts unmasked
  output logic [7:0]                wide_stack_pointer_q,   // Wide pointer
  output logic [7:0]                nibble_stack_pointer_q, // Nibble pointer
  output logic [3:0]                flags_q,        // Flag register E,I,C,Z
  output logic                      mem_req_q,      // Memory access strobe
  output logic                      mem_wr_q,       // Memory write
  output logic                      mem_wide_q,     // 16-bit access
  output logic [15:0]               mem_addr_q,     // Nibble address
  output logic [15:0]               mem_wdata_q,    // Write data
  output logic                      sel_ram_q,      // RAM selected
  output logic                      sel_drom_q,     // Data ROM selected
  output logic                      sel_disp_q,     // Display memory selected
  output logic                      sel_io_q,       // Peripheral I/O selected
  output logic                      map_err_q       // Illegal access
);

  if (IRQ_COUNT < 1 || IRQ_COUNT > mmsig_pkg::IRQ_COUNT_MAX) begin : g_bad_count
    $error("IRQ_COUNT must lie between 1 and 6");
  end

  mmsig_pkg::mmsig_state_type state_q, state_d;
  logic       wide_set_q, nib_set_q;
  logic       nmi_pend_q, take_nmi_q;
  logic [2:0] irq_idx_q;
  logic [15:0] save_pc_q;

  // Operation acceptance
  wire idle      = (state_q == mmsig_pkg::ST_IDLE);
  wire irq_any   = |irq_req;
  wire take_nmi  = idle & gate_open & nmi_pend_q;
  wire take_irq  = idle & gate_open & ~nmi_pend_q & irq_any
                   & flags_q[mmsig_pkg::FLAG_I_BIT];
  wire take_int  = take_nmi | take_irq;
  assign op_ready = idle & ~take_int;
  wire acc_wide_ld = op_ready & wide_stack_pointer_wr;
  wire acc_nib_ld  = op_ready & nibble_stack_pointer_wr;
  wire acc_call  = op_ready & op_call;
  wire acc_ret   = op_ready & ~op_call & op_ret;
  wire acc_npush = op_ready & ~op_call & ~op_ret & op_npush;
  wire acc_npop  = op_ready & ~op_call & ~op_ret & ~op_npush & op_npop;
  wire acc_data  = op_ready & ~op_call & ~op_ret & ~op_npush & ~op_npop & data_req;
  assign gate_open = wide_set_q & nib_set_q;

  // Pointer arithmetic; 8-bit pointers wrap by themselves
  wire [7:0]  wsp_dec   = 8'(wide_stack_pointer_q - 8'h01);
  wire [7:0]  wsp_inc   = 8'(wide_stack_pointer_q + 8'h01);
  wire [7:0]  nsp_dec   = 8'(nibble_stack_pointer_q - 8'h01);
  wire [7:0]  nsp_inc   = 8'(nibble_stack_pointer_q + 8'h01);
  wire [15:0] wide_push = {6'h00, wsp_dec, 2'h0};
  wire [15:0] wide_top  = {6'h00, wide_stack_pointer_q, 2'h0};
  wire [15:0] nib_push  = {8'h00, nsp_dec};
  wire [15:0] nib_top   = {8'h00, nibble_stack_pointer_q};

  // Lowest numbered pending interrupt wins
  logic [2:0] irq_pick;
  always_comb begin
    irq_pick = 3'h0;
    for (int i = IRQ_COUNT - 1; i >= 0; i--) begin
      if (irq_req[i]) begin
        irq_pick = 3'(i);
      end
    end
  end
  wire [15:0] irq_vec = 16'(mmsig_pkg::IRQ_VEC_BASE + {12'h000, irq_idx_q, 1'b0});

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      mmsig_pkg::ST_IDLE: begin
        if (take_int) begin
          state_d = mmsig_pkg::ST_INT_PC;
        end
      end
      mmsig_pkg::ST_INT_PC:   state_d = mmsig_pkg::ST_INT_FLAG;
      mmsig_pkg::ST_INT_FLAG: state_d = mmsig_pkg::ST_INT_VEC;
      mmsig_pkg::ST_INT_VEC:  state_d = mmsig_pkg::ST_IDLE;
    endcase
  end

  // Memory access mux: stack engine takes the bus before the CPU
  wire st_pc   = (state_q == mmsig_pkg::ST_INT_PC);
  wire st_flag = (state_q == mmsig_pkg::ST_INT_FLAG);
  wire st_vec  = (state_q == mmsig_pkg::ST_INT_VEC);
  wire wide_d  = st_pc | acc_call | acc_ret;
  wire req_d   = wide_d | st_flag | acc_npush | acc_npop | acc_data;
  wire wr_d    = st_pc | st_flag | acc_call | acc_npush | (acc_data & data_wr);
  wire [15:0] addr_d =
      (st_pc | acc_call) ? wide_push :
      acc_ret            ? wide_top  :
      (st_flag | acc_npush) ? nib_push :
      acc_npop           ? nib_top   : data_addr;
  wire [15:0] wdata_d =
      st_pc     ? save_pc_q :
      acc_call  ? call_pc   :
      st_flag   ? {12'h000, flags_q} :
      acc_npush ? {12'h000, npush_data} : {12'h000, data_wdata};

  // Data space decode
  wire in_ram  = (addr_d <= mmsig_pkg::RAM_LAST);
  wire in_wide = (addr_d >= mmsig_pkg::WIDE_FIRST) && (addr_d <= mmsig_pkg::WIDE_LAST);
  wire in_drom = (addr_d >= mmsig_pkg::DROM_FIRST) && (addr_d <= mmsig_pkg::DROM_LAST);
  wire in_disp = (addr_d >= DISP_FIRST) && (addr_d <= DISP_LAST);
  wire in_io   = (addr_d >= IO_FIRST) && (addr_d <= IO_LAST);
  // Flags accesses the hardware cannot honour; a wide stack off the window shows here too
  wire err_d   = req_d & (~(in_ram | in_drom | in_disp | in_io)
                 | (wide_d & ~in_wide) | (in_drom & wr_d));

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mem_req_q   <= 1'b0;
      mem_wr_q    <= 1'b0;
      mem_wide_q  <= 1'b0;
      mem_addr_q  <= 16'h0000;
      mem_wdata_q <= 16'h0000;
      sel_ram_q   <= 1'b0;
      sel_drom_q  <= 1'b0;
      sel_disp_q  <= 1'b0;
      sel_io_q    <= 1'b0;
      map_err_q   <= 1'b0;
    end else begin
      mem_req_q   <= req_d;
      mem_wr_q    <= wr_d;
      mem_wide_q  <= wide_d;
      mem_addr_q  <= addr_d;
      mem_wdata_q <= wdata_d;
      sel_ram_q   <= req_d & in_ram;
      sel_drom_q  <= req_d & in_drom;
      sel_disp_q  <= req_d & in_disp;
      sel_io_q    <= req_d & in_io;
      map_err_q   <= err_d;
    end
  end

  // Code ROM decode
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prog_hit_q      <= 1'b0;
      prog_rom_addr_q <= 13'h0000;
    end else begin
      prog_hit_q      <= prog_req & (prog_addr <= mmsig_pkg::PROG_LAST);
      prog_rom_addr_q <= prog_addr[mmsig_pkg::PROG_AW-1:0];
    end
  end

  // Pointers; the loaded value wins over any push or pop in the same cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wide_stack_pointer_q   <= mmsig_pkg::SP_RESET;
      nibble_stack_pointer_q <= mmsig_pkg::SP_RESET;
    end else begin
      if (acc_wide_ld) begin
        wide_stack_pointer_q <= sp_wdata;
      end else if (st_pc | acc_call) begin
        wide_stack_pointer_q <= wsp_dec;
      end else if (acc_ret) begin
        wide_stack_pointer_q <= wsp_inc;
      end
      if (acc_nib_ld) begin
        nibble_stack_pointer_q <= sp_wdata;
      end else if (st_flag | acc_npush) begin
        nibble_stack_pointer_q <= nsp_dec;
      end else if (acc_npop) begin
        nibble_stack_pointer_q <= nsp_inc;
      end
    end
  end

  // Written indicators
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wide_set_q <= 1'b0;
      nib_set_q  <= 1'b0;
    end else begin
      wide_set_q <= acc_wide_ld
                    | (wide_set_q & ~(gate_open & acc_nib_ld & ~acc_wide_ld));
      nib_set_q  <= acc_nib_ld
                    | (nib_set_q & ~(gate_open & acc_wide_ld & ~acc_nib_ld));
    end
  end

  // Interrupt entry and PC loading
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q        <= mmsig_pkg::ST_IDLE;
      flags_q        <= mmsig_pkg::FLAG_RESET;
      pc_load_q      <= 1'b1;
      pc_load_addr_q <= mmsig_pkg::RESET_PC;
      int_ack_q      <= 1'b0;
      nmi_pend_q     <= 1'b0;
      take_nmi_q     <= 1'b0;
      irq_idx_q      <= 3'h0;
      save_pc_q      <= 16'h0000;
    end else begin
      state_q    <= state_d;
      // Masked NMI is dropped, not held; a new request beats the take
      nmi_pend_q <= (nmi_req & gate_open) | (nmi_pend_q & ~take_nmi & gate_open);
      if (take_int) begin
        take_nmi_q <= take_nmi;
        irq_idx_q  <= irq_pick;
        save_pc_q  <= cur_pc;
      end
      if (st_flag) begin
        flags_q[mmsig_pkg::FLAG_I_BIT] <= 1'b0;
      end else if (op_ready & flag_wr) begin
        flags_q <= flag_wdata;
      end
      pc_load_q      <= st_vec;
      int_ack_q      <= st_vec;
      pc_load_addr_q <= take_nmi_q ? mmsig_pkg::NMI_VEC : irq_vec;
    end
  end

  sequence s_pc_push;
    mem_req_q && mem_wr_q && mem_wide_q;
  endsequence
  sequence s_flag_push;
    mem_req_q && mem_wr_q && !mem_wide_q && (mem_wdata_q[15:4] == 12'h000);
  endsequence

  chk_prog_range: assert property (@(posedge ref_clk) disable iff (reset)
    $past(prog_req) && ($past(prog_addr) > mmsig_pkg::PROG_LAST) |-> !prog_hit_q)
    else $error("fetch above code ROM was reported as a hit");
  chk_boot_vector: assert property (@(posedge ref_clk)
    $past(reset) && !reset |-> pc_load_q && (pc_load_addr_q == mmsig_pkg::RESET_PC)
                               && !flags_q[mmsig_pkg::FLAG_I_BIT] && !gate_open)
    else $error("reset did not load the start address with interrupts masked");
  chk_nmi_vector: assert property (@(posedge ref_clk) disable iff (reset)
    take_nmi |-> ##4 (int_ack_q && pc_load_q && (pc_load_addr_q == mmsig_pkg::NMI_VEC)))
    else $error("NMI entry did not load its vector");
  chk_irq_vector: assert property (@(posedge ref_clk) disable iff (reset)
    int_ack_q && !take_nmi_q |-> (pc_load_addr_q >= mmsig_pkg::IRQ_VEC_BASE)
                                 && (pc_load_addr_q <= mmsig_pkg::IRQ_VEC_LAST))
    else $error("interrupt vector outside its table");
  chk_ram_decode: assert property (@(posedge ref_clk) disable iff (reset)
    mem_req_q && (mem_addr_q <= mmsig_pkg::RAM_LAST) |-> sel_ram_q && !sel_drom_q)
    else $error("RAM address not decoded as RAM");
  chk_wide_window: assert property (@(posedge ref_clk) disable iff (reset)
    mem_req_q && mem_wide_q && ((mem_addr_q < mmsig_pkg::WIDE_FIRST)
                               || (mem_addr_q > mmsig_pkg::WIDE_LAST)) |-> map_err_q)
    else $error("wide access outside window not flagged");
  chk_sp_wrap: assert property (@(posedge ref_clk) disable iff (reset)
    acc_call && !acc_wide_ld && (wide_stack_pointer_q == 8'h00)
    |=> (wide_stack_pointer_q == 8'hFF))
    else $error("wide pointer did not wrap");
  chk_wide_stack_only: assert property (@(posedge ref_clk) disable iff (reset)
    acc_data |=> !mem_wide_q && (mem_addr_q == $past(data_addr)))
    else $error("plain data access was not a nibble access");
  chk_gate_mask: assert property (@(posedge ref_clk) disable iff (reset)
    !gate_open |-> !take_int ##1 (state_q == mmsig_pkg::ST_IDLE))
    else $error("interrupt taken while masked");
  chk_gate_rearm: assert property (@(posedge ref_clk) disable iff (reset)
    gate_open && acc_wide_ld && !acc_nib_ld |=> !gate_open && wide_set_q)
    else $error("rewriting one pointer did not mask interrupts");
  chk_call_push: assert property (@(posedge ref_clk) disable iff (reset)
    acc_call |=> s_pc_push and (mem_wdata_q == $past(call_pc)))
    else $error("call did not push the return address");
  chk_int_push: assert property (@(posedge ref_clk) disable iff (reset)
    take_int |-> ##2 s_pc_push ##1 s_flag_push)
    else $error("interrupt entry pushes out of order");
  chk_drom_decode: assert property (@(posedge ref_clk) disable iff (reset)
    mem_req_q && (mem_addr_q >= mmsig_pkg::DROM_FIRST) && (mem_addr_q <= mmsig_pkg::DROM_LAST)
    |-> sel_drom_q && (map_err_q == mem_wr_q))
    else $error("data ROM decode wrong");

endmodule
`default_nettype wire

// ---- mmsig_pkg.sv ----
`default_nettype none
package mmsig_pkg;

  // Program space
  localparam logic [15:0] PROG_LAST    = 16'h1FFF;
  localparam logic [15:0] RESET_PC     = 16'h0110;
  localparam logic [15:0] NMI_VEC      = 16'h0100;
  localparam logic [15:0] IRQ_VEC_BASE = 16'h0104;
  localparam logic [15:0] IRQ_VEC_LAST = 16'h010E;
  localparam int          PROG_AW      = 13;

  // Data space
  localparam logic [15:0] RAM_LAST   = 16'h13FF;
  localparam logic [15:0] WIDE_FIRST = 16'h0100;
  localparam logic [15:0] WIDE_LAST  = 16'h01FF;
  localparam logic [15:0] DROM_FIRST = 16'h8000;
  localparam logic [15:0] DROM_LAST  = 16'h87FF;

  // Default placement of display and I/O memory
  localparam logic [15:0] DISP_FIRST_DEF = 16'hF000;
  localparam logic [15:0] DISP_LAST_DEF  = 16'hF0FF;
  localparam logic [15:0] IO_FIRST_DEF   = 16'hFF00;
  localparam logic [15:0] IO_LAST_DEF    = 16'hFFFF;

  // Stack pointers and flags
  localparam logic [7:0] SP_RESET   = 8'h00;
  localparam logic [3:0] FLAG_RESET = 4'h0;
  localparam int         FLAG_Z_BIT = 0;
  localparam int         FLAG_C_BIT = 1;
  localparam int         FLAG_I_BIT = 2;
  localparam int         FLAG_E_BIT = 3;
  localparam int         IRQ_COUNT_MAX = 6;

  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_INT_PC   = 2'b01,
    ST_INT_FLAG = 2'b10,
    ST_INT_VEC  = 2'b11
  } mmsig_state_type;

endpackage
`default_nettype wire
